// *** core/msp_pkg.sv ***
// Shared constants, types and register layout of the microstep sequencer.
package msp_pkg;

   // ***********************************************************
   // Timing
   // ***********************************************************
   localparam int CLK_MHZ = 125;
   // Each charge and transfer phase lasts at least this long; the count rounds up.
   localparam int PUMP_PHASE_NS = 1000;
   localparam int PUMP_PHASE_CYC = (PUMP_PHASE_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0] PUMP_LAST = 8'(PUMP_PHASE_CYC - 1);

   // ***********************************************************
   // Register map and bus
   // ***********************************************************
   localparam int WB_AW = 4;
   localparam int SYNC_W = 8;
   localparam int MODE_W = 3;
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_CURRENT = 4'h8;
   localparam int CTRL_OVR_BIT = 0;
   localparam int CTRL_MODE_LSB = 1;

   // ***********************************************************
   // Electrical angle, 64 positions per turn
   // ***********************************************************
   localparam logic [5:0] ANGLE_RST = 6'h00;
   localparam logic [5:0] FULL_ORIGIN = 6'h08;
   localparam logic [5:0] QTR_TURN = 6'h10;
   localparam logic [3:0] LO_MID = 4'h8;
   localparam logic [3:0] MAG_FULL = 4'hF;
   localparam logic [5:0] STEP_FULL = 6'h10;
   localparam logic [5:0] STEP_HALF = 6'h08;
   localparam logic [5:0] STEP_QUARTER = 6'h04;
   localparam logic [5:0] STEP_EIGHTH = 6'h02;
   localparam logic [5:0] STEP_SIXTEENTH = 6'h01;
   localparam logic [5:0] STEP_NONE = 6'h00;
   // Quarter-wave sine, index 0 (0 deg) to 16 (90 deg), 4-bit magnitude.
   localparam logic [16:0][3:0] SINE_TAB = {4'hF, 4'hF, 4'hF, 4'hE, 4'hE, 4'hD,
      4'hC, 4'hC, 4'hB, 4'hA, 4'h8, 4'h7, 4'h6, 4'h4, 4'h3, 4'h1, 4'h0};

   // ***********************************************************
   // Types
   // ***********************************************************
   typedef enum logic [2:0] {
      MODE_LOWPWR = 3'h0, MODE_LOCK = 3'h1, MODE_FULL = 3'h2, MODE_HALF_A = 3'h3,
      MODE_HALF_B = 3'h4, MODE_QUARTER = 3'h5, MODE_EIGHTH = 3'h6,
      MODE_SIXTEENTH = 3'h7
   } msp_mode_t;

   typedef enum logic [3:0] {
      PS_IDLE = 4'h1, PS_CHARGE = 4'h2, PS_XFER = 4'h4, PS_STEADY = 4'h8
   } msp_pump_st_t;

   typedef struct packed {
      msp_pump_st_t st;
      logic [7:0] cnt;
   } msp_pump_t;
   localparam msp_pump_t PUMP_RST = '{st: PS_IDLE, cnt: 8'h00};

   typedef struct packed {
      logic [13:0] zero;
      logic steady;
      logic xfer;
      logic chg;
      logic on;
      logic dir;
      msp_mode_t pend;
      msp_mode_t act;
      logic origin;
      logic [5:0] angle;
   } msp_status_t;

   typedef struct packed {
      logic [15:0] zero;
      logic b_en;
      logic b_neg;
      logic [1:0] b_rsv;
      logic [3:0] b_mag;
      logic a_en;
      logic a_neg;
      logic [1:0] a_rsv;
      logic [3:0] a_mag;
   } msp_current_t;

   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
      logic ovr;
      msp_mode_t sw_mode;
      logic step_prev;
      logic dir;
      logic [5:0] angle;
      msp_mode_t act;
      msp_mode_t pend;
      logic on;
      logic origin;
      logic [1:0] ph_en;
      logic [1:0] ph_neg;
      logic [1:0][3:0] ph_mag;
   } msp_seq_t;
   localparam msp_seq_t SEQ_RST = '0;

endpackage

// *** core/msp_pump.sv ***
// Charge-pump switch sequencer: charge, transfer, steady.
`timescale 1ns/100ps
module msp_pump (
   input wire logic i_clk,
   input wire logic i_rst,
   msp_pump_if.pump pif
);
   import msp_pkg::*;
   msp_pump_t r;
   msp_pump_t n;

   // Next-state logic of the pump phases.
   always_comb begin
      n = r;
      n.cnt = r.cnt + 8'h01;
      unique case (r.st)
         PS_IDLE: begin
            n.st = PS_CHARGE;
            n.cnt = 8'h00;
         end
         PS_CHARGE: begin
            if (r.cnt == PUMP_LAST) begin
               n.st = PS_XFER;
               n.cnt = 8'h00;
            end
         end
         PS_XFER: begin
            if (r.cnt == PUMP_LAST) begin
               n.st = pif.boost_ok ? PS_STEADY : PS_CHARGE;
               n.cnt = 8'h00;
            end
         end
         PS_STEADY: begin
            n.cnt = 8'h00;
            if (!pif.boost_ok) begin
               n.st = PS_CHARGE;
            end
         end
         default: begin
            n = PUMP_RST;
         end
      endcase
      if (!pif.run) begin
         n = PUMP_RST;
      end
   end

   // State register.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         r <= PUMP_RST;
      end else begin
         r <= n;
      end
   end

   assign pif.chg = (r.st == PS_CHARGE);
   assign pif.xfer = (r.st == PS_XFER);
   assign pif.steady = (r.st == PS_STEADY);

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   chk_pump_first_charge: assert property (
      (r.st == PS_IDLE && pif.run) |=> pif.chg && !pif.xfer)
      else $error("pump did not start by charging");
   chk_pump_transfer: assert property (
      (pif.chg && r.cnt == PUMP_LAST && pif.run) |=> pif.xfer && !pif.chg)
      else $error("pump did not move to transfer");
   chk_pump_steady: assert property (
      (pif.xfer && r.cnt == PUMP_LAST && pif.run && pif.boost_ok) |=> pif.steady)
      else $error("pump did not settle when boosted");
   chk_pump_resume: assert property (
      (pif.steady && !pif.boost_ok && pif.run) |=> pif.chg)
      else $error("pump did not resume after voltage drop");
endmodule

// *** core/msp_pump_if.sv ***
// Handshake between the sequencer and its charge-pump controller.
`timescale 1ns/100ps
interface msp_pump_if;
   logic run;
   logic boost_ok;
   logic chg;
   logic xfer;
   logic steady;
   modport ctl (output run, output boost_ok, input chg, input xfer, input steady);
   modport pump (input run, input boost_ok, output chg, output xfer, output steady);
endinterface

// *** core/msp_sequencer.sv ***
// Microstep phase sequencer with charge-pump control and Wishbone registers.
//
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/100ps
module msp_sequencer (
   input wire logic I_MCLK,
   input wire logic I_SYS_RST,
   input wire logic I_STEP_CLK,
   input wire logic I_ROT_DIR,
   input wire logic [msp_pkg::MODE_W-1:0] I_MODE,
   input wire logic I_SEQ_RESET,
   input wire logic I_STANDBY_N,
   input wire logic I_BOOST_OK,
   input wire logic I_WB_CYC,
   input wire logic I_WB_STB,
   input wire logic I_WB_WE,
   input wire logic [msp_pkg::WB_AW-1:0] I_WB_ADR,
   input wire logic [3:0] I_WB_SEL,
   input wire logic [31:0] I_WB_DAT,
   output logic [31:0] O_WB_DAT,
   output logic O_WB_ACK,
   output logic O_PHASE_A_EN,
   output logic O_PHASE_A_NEG,
   output logic [3:0] O_PHASE_A_MAG,
   output logic O_PHASE_B_EN,
   output logic O_PHASE_B_NEG,
   output logic [3:0] O_PHASE_B_MAG,
   output logic O_ANGLE_ORIGIN,
   output logic O_PUMP_CHARGE_SWITCH,
   output logic O_PUMP_TRANSFER_SWITCH
);
   import msp_pkg::*;

   // ***********************************************************
   // Declarations
   // ***********************************************************
   msp_seq_t r;
   msp_seq_t n;
   logic [SYNC_W-1:0] sync_q;
   logic step_s;
   logic dir_s;
   logic rst_s;
   logic stby_n_s;
   logic [MODE_W-1:0] mode_s;
   logic boost_s;
   msp_mode_t req;
   logic step_edge;
   logic at_origin;
   logic flat_top;
   logic [1:0] ph_neg;
   logic [1:0][3:0] ph_mag;
   msp_status_t status;
   msp_current_t current;
   msp_pump_if pif ();

   // Angle advance per step clock for each mode.
   function automatic logic [5:0] step_of(input msp_mode_t m);
      logic [5:0] s;
      s = STEP_NONE;
      unique case (m)
         MODE_FULL: s = STEP_FULL;
         MODE_HALF_A: s = STEP_HALF;
         MODE_HALF_B: s = STEP_HALF;
         MODE_QUARTER: s = STEP_QUARTER;
         MODE_EIGHTH: s = STEP_EIGHTH;
         MODE_SIXTEENTH: s = STEP_SIXTEENTH;
         MODE_LOCK: s = STEP_SIXTEENTH;
         MODE_LOWPWR: s = STEP_NONE;
      endcase
      return s;
   endfunction

   // Position at which a reserved mode change is allowed to take over.
   function automatic logic [5:0] origin_of(input msp_mode_t m);
      return (m == MODE_FULL) ? FULL_ORIGIN : ANGLE_RST;
   endfunction

   // ***********************************************************
   // Pin synchronisation
   // ***********************************************************
   // All host pins are asynchronous to I_MCLK and pass two flops.
   msp_sync #(
      .W(SYNC_W)
   ) u_sync (
      .i_clk(I_MCLK),
      .i_rst(I_SYS_RST),
      .i_async({I_STEP_CLK, I_ROT_DIR, I_SEQ_RESET, I_STANDBY_N, I_MODE, I_BOOST_OK}),
      .o_sync(sync_q)
   );

   // Unpack the synchronised levels.
   assign {step_s, dir_s, rst_s, stby_n_s, mode_s, boost_s} = sync_q;

   // ***********************************************************
   // Charge pump
   // ***********************************************************
   // pump idle during reset
   assign pif.run = r.on && !rst_s;
   assign pif.boost_ok = boost_s;

   msp_pump u_pump (
      .i_clk(I_MCLK),
      .i_rst(I_SYS_RST),
      .pif(pif)
   );

   // ***********************************************************
   // Current decode
   // ***********************************************************
   // Full step and the second half-step variant drive both phases at
   // full scale at 45 degrees instead of the sine value there.
   assign flat_top = (r.act == MODE_FULL) || (r.act == MODE_HALF_B);

   // One decoder per phase; phase B leads phase A by a quarter turn.
   for (genvar p = 0; p < 2; p++) begin : g_phase
      logic [5:0] ang;
      logic [4:0] k;
      logic [3:0] mag;
      assign ang = r.angle + ((p == 0) ? ANGLE_RST : QTR_TURN);
      assign k = ang[4] ? (5'h10 - {1'b0, ang[3:0]}) : {1'b0, ang[3:0]};
      assign mag = (flat_top && ang[3:0] == LO_MID) ? MAG_FULL : SINE_TAB[k];
      assign ph_mag[p] = mag;
      assign ph_neg[p] = ang[5] && (mag != 4'h0);
   end

   // Mode asked for by software override or by the mode pins.
   assign req = r.ovr ? r.sw_mode : msp_mode_t'(mode_s);
   assign step_edge = step_s && !r.step_prev;
   assign at_origin = (r.angle == origin_of(r.act));

   // ***********************************************************
   // Register views
   // ***********************************************************
   always_comb begin
      status = '0;
      status.steady = pif.steady;
      status.xfer = pif.xfer;
      status.chg = pif.chg;
      status.on = r.on;
      status.dir = r.dir;
      status.pend = r.pend;
      status.act = r.act;
      status.origin = r.origin;
      status.angle = r.angle;
      current = '0;
      current.a_en = r.ph_en[0];
      current.a_neg = r.ph_neg[0];
      current.a_mag = r.ph_mag[0];
      current.b_en = r.ph_en[1];
      current.b_neg = r.ph_neg[1];
      current.b_mag = r.ph_mag[1];
   end

   // ***********************************************************
   // Next state
   // ***********************************************************
   always_comb begin
      n = r;

      // Wishbone slave: one wait state, ack for one cycle per access.
      // Unmapped offsets are acknowledged and read as zero so that a
      // stray access never hangs the bus.
      n.ack = I_WB_CYC && I_WB_STB && !r.ack;
      // A write lands at the edge where the master samples ack high, so a
      // request withdrawn before that edge leaves the register untouched.
      if (r.ack && I_WB_CYC && I_WB_STB && I_WB_WE && I_WB_SEL[0]
          && I_WB_ADR == REG_CTRL) begin
         n.ovr = I_WB_DAT[CTRL_OVR_BIT];
         n.sw_mode = msp_mode_t'(I_WB_DAT[CTRL_MODE_LSB +: MODE_W]);
      end
      n.rdat = '0;
      if (n.ack && !I_WB_WE) begin
         case (I_WB_ADR)
            REG_CTRL: n.rdat[CTRL_MODE_LSB +: MODE_W] = r.sw_mode;
            REG_STATUS: n.rdat = status;
            REG_CURRENT: n.rdat = current;
            default: n.rdat = '0;
         endcase
         n.rdat[CTRL_OVR_BIT] = (I_WB_ADR == REG_CTRL) ? r.ovr : n.rdat[CTRL_OVR_BIT];
      end

      // Step clock edge detect on the synchronised level.
      n.step_prev = step_s;
      n.pend = req;

      // low power acts as standby
      // Entering or leaving low power is not reserved: it takes effect at
      // once, because it only gates the drive and leaves the angle alone.
      if (req == MODE_LOWPWR || r.act == MODE_LOWPWR) begin
         n.act = req;
      end

      if (rst_s) begin
         n.act = req;
         n.angle = origin_of(req);
      end else if (step_edge && r.on) begin
         n.dir = dir_s;
         if (at_origin && req != MODE_LOWPWR) begin
            n.act = req;
         end
         if (n.act == MODE_FULL) begin
            // full step on 45 degree lattice
            // A switch into full step at 0 degrees lands on the
            // neighbouring 45 degree point rather than skipping one.
            if (dir_s) begin
               n.angle[5:4] = (r.angle[3:0] < LO_MID) ? r.angle[5:4] : r.angle[5:4] + 2'h1;
            end else begin
               n.angle[5:4] = (r.angle[3:0] > LO_MID) ? r.angle[5:4] : r.angle[5:4] - 2'h1;
            end
            n.angle[3:0] = LO_MID;
         end else if (dir_s) begin
            n.angle = r.angle + step_of(n.act);
         end else begin
            n.angle = r.angle - step_of(n.act);
         end
      end

      n.on = stby_n_s && (n.act != MODE_LOWPWR);
      n.origin = (n.angle == origin_of(n.act));

      // Phase outputs are registered one cycle behind the angle.
      n.ph_en = {r.on, r.on};
      n.ph_neg = ph_neg;
      n.ph_mag = ph_mag;
   end

   // ***********************************************************
   // State register
   // ***********************************************************
   always_ff @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         r <= SEQ_RST;
      end else begin
         r <= n;
      end
   end

   // ***********************************************************
   // Outputs
   // ***********************************************************
   assign O_WB_ACK = r.ack;
   assign O_WB_DAT = r.rdat;
   assign O_PHASE_A_EN = r.ph_en[0];
   assign O_PHASE_A_NEG = r.ph_neg[0];
   assign O_PHASE_A_MAG = r.ph_mag[0];
   assign O_PHASE_B_EN = r.ph_en[1];
   assign O_PHASE_B_NEG = r.ph_neg[1];
   assign O_PHASE_B_MAG = r.ph_mag[1];
   assign O_ANGLE_ORIGIN = r.origin;
   assign O_PUMP_CHARGE_SWITCH = pif.chg;
   assign O_PUMP_TRANSFER_SWITCH = pif.xfer;

   // ***********************************************************
   // Checks
   // ***********************************************************
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (I_SYS_RST);

   chk_lowpwr_off: assert property (
      !r.on |=> (r.ph_en == 2'b00) && !pif.chg && !pif.xfer)
      else $error("drive or pump active while off");
   chk_standby_equal: assert property (
      (r.act == MODE_LOWPWR || !$past(stby_n_s))
      |=> (r.ph_en == 2'b00) && !pif.chg && !pif.xfer)
      else $error("low power differs from standby");
   chk_lock_start: assert property (
      (rst_s && req == MODE_LOCK) |-> ##2 (r.ph_mag[0] == 4'h0 && r.ph_mag[1] == MAG_FULL))
      else $error("lock mode does not start at A zero B full");
   chk_full_lattice: assert property (
      (step_edge && r.on && !rst_s && r.act == MODE_FULL && req == MODE_FULL
       && r.angle[3:0] == LO_MID)
      |=> (r.angle[3:0] == LO_MID) && (r.angle[5:4] != $past(r.angle[5:4])))
      else $error("full step left the 45 degree lattice");
   chk_step_size: assert property (
      (step_edge && r.on && !rst_s && !at_origin && r.act != MODE_FULL)
      |=> ((r.dir ? r.angle - $past(r.angle) : $past(r.angle) - r.angle)
           == step_of($past(r.act))))
      else $error("angle moved by a wrong step");
   chk_dir_sample: assert property (
      (step_edge && r.on && !rst_s) |=> (r.dir == $past(dir_s)))
      else $error("direction not taken at step edge");
   chk_mode_reserve: assert property (
      (step_edge && r.on && !rst_s && !at_origin && req != MODE_LOWPWR)
      |=> (r.act == $past(r.act)))
      else $error("mode changed away from origin");
   chk_reset_hold: assert property (
      (rst_s && req != MODE_FULL) |=> (r.angle == ANGLE_RST) && !pif.chg && !pif.xfer)
      else $error("reset did not hold angle and pump");

   // Per-mode step size and quarter-step current levels, steps taken at the origin included.
   chk_lock_step: assert property (
      (step_edge && r.on && !rst_s && r.act == MODE_LOCK && req == r.act)
      |=> ((r.dir ? r.angle - $past(r.angle) : $past(r.angle) - r.angle) == STEP_SIXTEENTH))
      else $error("lock mode moved by a wrong step");
   chk_full_step: assert property (
      (step_edge && r.on && !rst_s && r.act == MODE_FULL && req == r.act)
      |=> (r.angle[3:0] == LO_MID))
      else $error("full step off the 45 degree points");
   chk_half_step: assert property (
      (step_edge && r.on && !rst_s && (r.act == MODE_HALF_A || r.act == MODE_HALF_B)
       && req == r.act)
      |=> ((r.dir ? r.angle - $past(r.angle) : $past(r.angle) - r.angle) == STEP_HALF))
      else $error("half step moved by a wrong amount");
   chk_quarter_step: assert property (
      (step_edge && r.on && !rst_s && r.act == MODE_QUARTER && req == r.act)
      |=> ((r.dir ? r.angle - $past(r.angle) : $past(r.angle) - r.angle) == STEP_QUARTER))
      else $error("quarter step moved by a wrong amount");
   chk_quarter_levels: assert property (
      (r.act == MODE_QUARTER && r.angle[1:0] == 2'b00)
      |=> (r.ph_mag[0] inside {4'h0, 4'h6, 4'hB, 4'hE, 4'hF})
          && (r.ph_mag[1] inside {4'h0, 4'h6, 4'hB, 4'hE, 4'hF}))
      else $error("quarter step current off its levels");
   chk_eighth_step: assert property (
      (step_edge && r.on && !rst_s && r.act == MODE_EIGHTH && req == r.act)
      |=> ((r.dir ? r.angle - $past(r.angle) : $past(r.angle) - r.angle) == STEP_EIGHTH))
      else $error("eighth step moved by a wrong amount");
   chk_sixteenth_step: assert property (
      (step_edge && r.on && !rst_s && r.act == MODE_SIXTEENTH && req == r.act)
      |=> ((r.dir ? r.angle - $past(r.angle) : $past(r.angle) - r.angle) == STEP_SIXTEENTH))
      else $error("sixteenth step moved by a wrong amount");
endmodule

// *** core/msp_sync.sv ***
// Two-flop synchroniser for a vector of unrelated pin levels.
`timescale 1ns/100ps
module msp_sync #(
   parameter int W = 1
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } msp_sync_t;
   msp_sync_t r;
   msp_sync_t n;

   // The first stage feeds only the second stage.
   always_comb begin
      n.s1 = i_async;
      n.s2 = r.s1;
   end

   // Registers both stages.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign o_sync = r.s2;
endmodule

// *** dv/msp_host_model.sv ***
// Host controller model that drives the step, direction, mode and standby pins.
`timescale 1ns/100ps
module msp_host_model (
   input wire logic i_clk,
   output logic o_step,
   output logic o_dir,
   output logic [msp_pkg::MODE_W-1:0] o_mode,
   output logic o_seq_reset,
   output logic o_standby_n
);
   import msp_pkg::*;

   // ********************
   // Fixed host settings
   // ********************
   // format select low.
   localparam logic FMT_SEL = 1'b0; // Only clock-in stepping is ever used.
   localparam int DECAY_PERMILLE = 375; // Fixed; the host never changes it.

   // Pins start in standby with the sequencer held at home.
   initial begin
      o_step = 1'b0;
      o_dir = 1'b1;
      o_mode = MODE_LOWPWR;
      o_seq_reset = 1'b1;
      o_standby_n = 1'b0;
   end

   // Each level stands at least four cycles, so the two-flop synchroniser never merges edges.
   task automatic step(input int n);
      repeat (n) begin
         @(posedge i_clk);
         o_step <= 1'b1;
         repeat (4) @(posedge i_clk);
         o_step <= 1'b0;
         repeat (4) @(posedge i_clk);
      end
   endtask

   // Level pins change together, then settle through the synchronisers.
   task automatic set_pins(input logic dir, input logic [2:0] mode, input logic stby_n);
      @(posedge i_clk);
      o_dir <= dir;
      o_mode <= mode;
      o_standby_n <= stby_n;
      repeat (6) @(posedge i_clk);
   endtask

   task automatic reinit(input logic [2:0] mode);
      @(posedge i_clk);
      o_seq_reset <= 1'b1;
      o_mode <= mode;
      repeat (6) @(posedge i_clk);
      o_seq_reset <= 1'b0;
      repeat (6) @(posedge i_clk);
   endtask
endmodule

// *** dv/msp_sequencer_tb_top.sv ***
// Self-checking bench for the microstep sequencer.
`timescale 1ns/100ps
module msp_sequencer_tb_top;
   import msp_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic boost_ok = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wdat = 32'h0000_0000;
   logic [3:0] sel = 4'h0;
   logic [3:0] wsel = 4'hF;
   logic [31:0] rdat;
   wire logic step, dir, seq_rst, stby_n;
   wire logic [2:0] mode;
   wire logic [31:0] wb_dat;
   wire logic wb_ack, a_en, a_neg, b_en, b_neg, origin, chg, xfer;
   wire logic [3:0] a_mag, b_mag;
   int n_errors = 0;
   int comparisons = 0;
   msp_mode_t tmode [6] = '{MODE_FULL, MODE_HALF_A, MODE_HALF_B, MODE_QUARTER,
      MODE_EIGHTH, MODE_SIXTEENTH};
   int tsteps [6] = '{4, 8, 8, 16, 32, 64};
   logic [5:0] tstart [6] = '{FULL_ORIGIN, ANGLE_RST, ANGLE_RST, ANGLE_RST, ANGLE_RST,
      ANGLE_RST};
   logic [3:0] qlev [5] = '{4'h0, 4'h6, 4'hB, 4'hE, 4'hF};

   // Free-running system clock, 8 ns period.
   initial begin
      forever #4 clk = ~clk;
   end

   msp_host_model msp_host_model_i (.i_clk(clk), .o_step(step), .o_dir(dir),
      .o_mode(mode), .o_seq_reset(seq_rst), .o_standby_n(stby_n));

   msp_sequencer msp_sequencer_i (.I_MCLK(clk), .I_SYS_RST(rst), .I_STEP_CLK(step),
      .I_ROT_DIR(dir), .I_MODE(mode), .I_SEQ_RESET(seq_rst), .I_STANDBY_N(stby_n),
      .I_BOOST_OK(boost_ok), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
      .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(wb_dat),
      .O_WB_ACK(wb_ack), .O_PHASE_A_EN(a_en), .O_PHASE_A_NEG(a_neg),
      .O_PHASE_A_MAG(a_mag), .O_PHASE_B_EN(b_en), .O_PHASE_B_NEG(b_neg),
      .O_PHASE_B_MAG(b_mag), .O_ANGLE_ORIGIN(origin), .O_PUMP_CHARGE_SWITCH(chg),
      .O_PUMP_TRANSFER_SWITCH(xfer));

   // ********************
   // Shared tasks
   // ********************
   // Prints the verdict once and stops the run.
   task automatic end_of_test();
      if (n_errors == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Four-state compare, so an unknown never counts as a match.
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // A wait that ran out is counted and ends the run.
   task automatic give_up(input string what);
      n_errors++;
      $display("MISMATCH %s expected done seen timeout", what);
      end_of_test();
   endtask

   // Classic single cycle; the request stands until ack is sampled high.
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= wsel;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (wb_ack === 1'b1) break;
      end
      if (i == 20) give_up("bus ack");
      rdat = wb_dat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      sel <= 4'h0;
   endtask

   // Waits for a pump switch to reach a level; a pump phase lasts 125 cycles.
   task automatic wait_sw(input logic sel_xfer, input logic val);
      int i;
      for (i = 0; i < 600; i++) begin
         @(posedge clk);
         if ((sel_xfer ? xfer : chg) === val) break;
      end
      if (i == 600) give_up("pump switch");
   endtask

   // ********************
   // Main sequence
   // ********************
   initial begin : main
      logic [31:0] st;
      int k;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check("idle outputs", {a_en, b_en, chg, xfer, origin}, 5'h00);
      wb(1'b0, REG_CTRL, 32'h0000_0000);
      check("ctrl reset", rdat, 32'h0000_0000);
      wb(1'b1, REG_CTRL, 32'h0000_000E);
      wb(1'b0, REG_CTRL, 32'h0000_0000);
      check("ctrl readback", rdat, 32'h0000_000E);
      // A write without its low byte lane enabled is ignored.
      wsel = 4'hE;
      wb(1'b1, REG_CTRL, 32'h0000_0001);
      wsel = 4'hF;
      wb(1'b0, REG_CTRL, 32'h0000_0000);
      check("ctrl lane off", rdat, 32'h0000_000E);
      wb(1'b1, REG_CTRL, 32'h0000_0000);
      wb(1'b0, 4'hC, 32'h0000_0000);
      check("unmapped read", rdat, 32'h0000_0000);
      // Pump stays idle while the sequencer reset pin is high.
      msp_host_model_i.set_pins(1'b1, MODE_LOCK, 1'b1);
      check("pump held", {chg, xfer}, 2'h0);
      msp_host_model_i.reinit(MODE_LOCK);
      wait_sw(1'b0, 1'b1);
      check("xfer in charge", xfer, 1'b0);
      wait_sw(1'b1, 1'b1);
      check("charge in xfer", chg, 1'b0);
      wait_sw(1'b0, 1'b1);
      boost_ok <= 1'b1;
      wait_sw(1'b1, 1'b1);
      wait_sw(1'b1, 1'b0);
      repeat (4) @(posedge clk);
      check("steady switches", {chg, xfer}, 2'h0);
      wb(1'b0, REG_STATUS, 32'h0000_0000);
      check("steady flag", rdat[17], 1'b1);
      boost_ok <= 1'b0;
      wait_sw(1'b0, 1'b1);
      check("pump resumes", {chg, xfer}, 2'h2);
      boost_ok <= 1'b1;
      repeat (300) @(posedge clk);
      check("lock phase a", {a_en, a_mag}, 5'h10);
      check("lock phase b", {b_en, b_mag}, 5'h1F);
      msp_host_model_i.step(1);
      wb(1'b0, REG_STATUS, 32'h0000_0000);
      check("lock step", rdat[5:0], 6'h01);
      // One full electrical turn in every stepping mode except lock.
      for (k = 0; k < 6; k++) begin
         msp_host_model_i.reinit(tmode[k]);
         msp_host_model_i.step(1);
         wb(1'b0, REG_STATUS, 32'h0000_0000);
         check("one step", rdat[5:0], tstart[k] + 6'(64 / tsteps[k]));
         msp_host_model_i.step(tsteps[k] - 2);
         check("origin early", origin, 1'b0);
         msp_host_model_i.step(1);
         wb(1'b0, REG_STATUS, 32'h0000_0000);
         check("turn end", {origin, rdat[5:0]}, {1'b1, tstart[k]});
      end
      // Quarter-step levels, then a late mode change that waits for origin.
      msp_host_model_i.reinit(MODE_QUARTER);
      for (k = 0; k < 5; k++) begin
         check("quarter level", a_mag, qlev[k]);
         msp_host_model_i.step(1);
      end
      msp_host_model_i.set_pins(1'b1, MODE_EIGHTH, 1'b1);
      msp_host_model_i.step(1);
      wb(1'b0, REG_STATUS, 32'h0000_0000);
      check("late mode held", {rdat[9:7], rdat[5:0]}, {MODE_QUARTER, 6'h18});
      msp_host_model_i.step(11);
      wb(1'b0, REG_STATUS, 32'h0000_0000);
      check("mode at origin", rdat[9:7], MODE_EIGHTH);
      msp_host_model_i.set_pins(1'b0, MODE_SIXTEENTH, 1'b1);
      msp_host_model_i.reinit(MODE_SIXTEENTH);
      msp_host_model_i.step(1);
      wb(1'b0, REG_STATUS, 32'h0000_0000);
      check("reverse step", rdat[5:0], 6'h3F);
      check("phase signs", {a_neg, a_mag, b_neg, b_mag}, 10'h22F);
      // Low power and standby both switch the drive and pump off.
      msp_host_model_i.set_pins(1'b0, MODE_LOWPWR, 1'b1);
      check("low power off", {a_en, b_en, chg, xfer}, 4'h0);
      msp_host_model_i.set_pins(1'b0, MODE_SIXTEENTH, 1'b0);
      wb(1'b0, REG_STATUS, 32'h0000_0000);
      st = rdat;
      msp_host_model_i.step(1);
      wb(1'b0, REG_STATUS, 32'h0000_0000);
      check("standby off", {a_en, b_en, chg, xfer, rdat[5:0]}, {4'h0, st[5:0]});
      // Software override asks for low power, which is taken at once.
      wb(1'b1, REG_CTRL, 32'h0000_0001);
      wb(1'b0, REG_STATUS, 32'h0000_0000);
      check("override mode", rdat[12:7], 6'h00);
      end_of_test();
   end
endmodule
